/* File: rtl/input32_channel_mapper.sv */
// 32-input mapper: pairs of inputs per converter onto sixteen lanes
`default_nettype none
module input32_channel_mapper #(
   parameter int BIT_DIV = 1
) (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic [7:0]                  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output var  logic                        s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output var  logic                        s_axi_wready,
   output var  logic [1:0]                  s_axi_bresp,
   output var  logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [7:0]                  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output var  logic                        s_axi_arready,
   output var  logic [31:0]                 s_axi_rdata,
   output var  logic [1:0]                  s_axi_rresp,
   output var  logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic                        sample_clock_pin,
   input  wire logic [15:0][11:0]           sample_in,
   output var  logic [15:0]                 input_select,
   output var  logic [15:0]                 converter_analog_powerdown,
   output var  logic [15:0]                 lane_data,
   output var  logic [15:0]                 lane_frame
);
   localparam int NC = mapper_pkg::NUM_CONV;
   localparam int W  = mapper_pkg::SAMPLE_W;
   if (BIT_DIV < 1 || BIT_DIV > 256) begin : g_check
      $error("BIT_DIV must lie between 1 and 256");
   end
   // ---------------------------------------------------------
   // register bus
   // ---------------------------------------------------------
   logic        aw_hold_q, w_hold_q, wr_fire;
   logic [7:0]  awaddr_q, rd_addr;
   logic [31:0] wdata_q, rd_word;
   logic [3:0]  wstrb_q;
   logic        wr_hit, rd_hit, trim_wr;
   logic        mode32_q, rate2x_q, refused_q;
   logic [15:0] converter_digital_powerdown, frames_q;
   logic [3:0]  highpass_filter_enable;
   logic [7:0]  highpass_corner_select;

   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire       = aw_hold_q && w_hold_q;
   assign trim_wr = wr_fire && awaddr_q[7:6] == 2'b01
                    && awaddr_q[1:0] == 2'b00;

   function automatic logic known(input logic [7:0] a);
      return a == mapper_pkg::CTRL_ADDR || a == mapper_pkg::STATUS_ADDR
          || a == mapper_pkg::DPDN_ADDR || a == mapper_pkg::APDN_ADDR
          || a == mapper_pkg::HPFEN_ADDR
          || a == mapper_pkg::CORNER_ADDR
          || (a[7:6] == 2'b01 && a[1:0] == 2'b00);
   endfunction : known

   assign wr_hit  = known(awaddr_q);
   assign rd_addr = s_axi_araddr;
   assign rd_hit  = known(rd_addr);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= mapper_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? mapper_pkg::RESP_OKAY
                                   : mapper_pkg::RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_addr)
         mapper_pkg::CTRL_ADDR: begin
            rd_word[mapper_pkg::MODE32_BIT] = mode32_q;
            rd_word[mapper_pkg::RATE2X_BIT] = rate2x_q;
         end
         mapper_pkg::STATUS_ADDR: begin
            rd_word[mapper_pkg::ACTIVE_BIT]  = mode32_q;
            rd_word[mapper_pkg::REFUSED_BIT] = refused_q;
            rd_word[31:mapper_pkg::FRAMES_LSB] = frames_q;
         end
         mapper_pkg::DPDN_ADDR: rd_word[15:0] = converter_digital_powerdown;
         mapper_pkg::APDN_ADDR: rd_word[15:0] = converter_analog_powerdown;
         mapper_pkg::HPFEN_ADDR: rd_word[3:0] = highpass_filter_enable;
         mapper_pkg::CORNER_ADDR: rd_word[7:0] = highpass_corner_select;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= mapper_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? mapper_pkg::RESP_OKAY
                                : mapper_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // ---------------------------------------------------------
   // control registers
   // ---------------------------------------------------------
   logic ctrl_wr, stat_wr, rate_ask;
   assign ctrl_wr  = wr_fire && awaddr_q == mapper_pkg::CTRL_ADDR
                     && wstrb_q[0];
   assign stat_wr  = wr_fire && awaddr_q == mapper_pkg::STATUS_ADDR
                     && wstrb_q[0];
   assign rate_ask = wdata_q[mapper_pkg::RATE2X_BIT];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode32_q  <= 1'b0;
         rate2x_q  <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            mode32_q <= wdata_q[mapper_pkg::MODE32_BIT];
            rate2x_q <= rate_ask && !wdata_q[mapper_pkg::MODE32_BIT];
         end
         if (ctrl_wr && rate_ask && wdata_q[mapper_pkg::MODE32_BIT]) begin
            refused_q <= 1'b1;
         end else if (stat_wr && wdata_q[mapper_pkg::REFUSED_BIT]) begin
            refused_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         converter_digital_powerdown <= 16'h0000;
         converter_analog_powerdown  <= 16'h0000;
         highpass_filter_enable      <= 4'h0;
         highpass_corner_select      <= 8'h00;
      end else if (wr_fire) begin
         for (int b = 0; b < 2; b++) begin
            if (wstrb_q[b] && awaddr_q == mapper_pkg::DPDN_ADDR) begin
               converter_digital_powerdown[8*b +: 8] <= wdata_q[8*b +: 8];
            end
            if (wstrb_q[b] && awaddr_q == mapper_pkg::APDN_ADDR) begin
               converter_analog_powerdown[8*b +: 8] <= wdata_q[8*b +: 8];
            end
         end
         if (wstrb_q[0] && awaddr_q == mapper_pkg::HPFEN_ADDR) begin
            highpass_filter_enable <= wdata_q[3:0];
         end
         if (wstrb_q[0] && awaddr_q == mapper_pkg::CORNER_ADDR) begin
            highpass_corner_select <= wdata_q[7:0];
         end
      end
   end
   // ---------------------------------------------------------
   // sampling instants
   // ---------------------------------------------------------
   logic [1:0] link_sync_q;
   logic       link_prev_q, edge_seen, select_q;
   mapper_pkg::pair_type [NC-1:0] raw_q;
   logic [NC-1:0][W-1:0] odd_next_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link_sync_q <= 2'b00;
         link_prev_q <= 1'b0;
      end else begin
         link_sync_q <= {link_sync_q[0], sample_clock_pin};
         link_prev_q <= link_sync_q[1];
      end
   end
   assign edge_seen = link_sync_q[1] && !link_prev_q && mode32_q;

   // odd words wait in odd_next_q: the trim walk outlasts one sampling
   // period, so the next odd instant must not touch the pair in use
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         select_q   <= 1'b0;
         raw_q      <= '0;
         odd_next_q <= '0;
      end else if (!mode32_q) begin
         select_q <= 1'b0;
      end else if (edge_seen) begin
         select_q <= !select_q;
         for (int c = 0; c < NC; c++) begin
            if (select_q) begin
               raw_q[c].even <= sample_in[c];
               raw_q[c].odd  <= odd_next_q[c];
            end else begin
               odd_next_q[c] <= sample_in[c];
            end
         end
      end
   end
   assign input_select = {NC{select_q}};
   // ---------------------------------------------------------
   // per-channel trim walk
   // ---------------------------------------------------------
   mapper_pkg::walk_type walk_q;
   logic [3:0]  walk_idx_q, stage_idx_q;
   logic        stage_v_q, bit_en;
   logic [31:0] trim_raw;
   mapper_pkg::trim_type trim;
   logic [15:0] avg_q [2*NC];
   mapper_pkg::pair_type [NC-1:0] frame_q;
   logic [1:0]  grp;
   logic        hp_on;
   logic [3:0]  shift_k;
   assign trim = mapper_pkg::trim_type'(trim_raw);
   assign grp  = stage_idx_q[3:2];
   assign hp_on   = highpass_filter_enable[grp];
   assign shift_k = 4'(highpass_corner_select[2*grp +: 2])
                    + 4'(mapper_pkg::CORNER_BASE);

   function automatic logic [W-1:0] trimmed(
      input logic [W-1:0] x, input logic hp, input logic [15:0] avg,
      input logic [7:0] gain, input logic [7:0] ofs);
      logic signed [W:0]   h;
      logic signed [W+9:0] p;
      h = hp ? $signed({x[W-1], x}) - $signed({avg[15], avg[15:4]})
             : $signed({x[W-1], x});
      p = h * $signed({1'b0, gain});
      p = (p >>> mapper_pkg::GAIN_FRAC) + (W+10)'($signed(ofs));
      return p[W-1:0];
   endfunction : trimmed

   function automatic logic [15:0] avg_next(
      input logic [W-1:0] x, input logic [15:0] avg, input logic [3:0] k);
      logic signed [16:0] d;
      d = $signed({x[W-1], x, 4'h0}) - $signed({avg[15], avg});
      return avg + 16'(d >>> k);
   endfunction : avg_next

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         walk_q      <= mapper_pkg::WALK_IDLE;
         walk_idx_q  <= 4'h0;
         stage_idx_q <= 4'h0;
         stage_v_q   <= 1'b0;
      end else begin
         stage_v_q   <= walk_q == mapper_pkg::WALK_READ;
         stage_idx_q <= walk_idx_q;
         case (walk_q)
            mapper_pkg::WALK_IDLE: begin
               walk_idx_q <= 4'h0;
               if (edge_seen && select_q) begin
                  walk_q <= mapper_pkg::WALK_READ;
               end
            end
            mapper_pkg::WALK_READ: begin
               walk_idx_q <= walk_idx_q + 4'h1;
               if (walk_idx_q == 4'hF) begin
                  walk_q <= mapper_pkg::WALK_LAST;
               end
            end
            mapper_pkg::WALK_LAST: walk_q <= mapper_pkg::WALK_FIRE;
            mapper_pkg::WALK_FIRE: walk_q <= mapper_pkg::WALK_IDLE;
            default: walk_q <= mapper_pkg::WALK_IDLE;
         endcase
      end
   end

   trim_memory #(.DEPTH(NC)) u_trim (
      .clk     (clk),
      .reset   (reset),
      .wr_en   (trim_wr),
      .wr_addr (awaddr_q[5:2]),
      .wr_data (wdata_q),
      .wr_strb (wstrb_q),
      .rd_addr (walk_idx_q),
      .rd_data (trim_raw)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         frame_q <= '0;
         for (int i = 0; i < 2*NC; i++) begin
            avg_q[i] <= 16'h0000;
         end
      end else if (stage_v_q) begin
         if (converter_digital_powerdown[stage_idx_q]
             || converter_analog_powerdown[stage_idx_q]) begin
            frame_q[stage_idx_q] <= '0;
         end else begin
            frame_q[stage_idx_q].odd <= trimmed(
               raw_q[stage_idx_q].odd, hp_on, avg_q[{stage_idx_q, 1'b0}],
               trim.odd_gain, trim.odd_offset);
            frame_q[stage_idx_q].even <= trimmed(
               raw_q[stage_idx_q].even, hp_on, avg_q[{stage_idx_q, 1'b1}],
               trim.even_gain, trim.even_offset);
            if (hp_on) begin
               avg_q[{stage_idx_q, 1'b0}] <= avg_next(
                  raw_q[stage_idx_q].odd, avg_q[{stage_idx_q, 1'b0}],
                  shift_k);
               avg_q[{stage_idx_q, 1'b1}] <= avg_next(
                  raw_q[stage_idx_q].even, avg_q[{stage_idx_q, 1'b1}],
                  shift_k);
            end
         end
      end
   end
   // ---------------------------------------------------------
   // lanes
   // ---------------------------------------------------------
   logic [7:0] div_q;
   logic       fire;
   assign fire = walk_q == mapper_pkg::WALK_FIRE;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_q    <= 8'h00;
         frames_q <= 16'h0000;
      end else begin
         div_q <= (div_q == 8'(BIT_DIV - 1)) ? 8'h00 : div_q + 8'h01;
         if (fire) begin
            frames_q <= frames_q + 16'h0001;
         end
      end
   end
   assign bit_en = div_q == 8'(BIT_DIV - 1);

   for (genvar n = 0; n < NC; n++) begin : g_lane
      lane_serializer u_lane (
         .clk         (clk),
         .reset       (reset),
         .bit_en      (bit_en),
         .load        (fire),
         .word        (frame_q[n]),
         .lane_bit    (lane_data[n]),
         .frame_start (lane_frame[n])
      );
   end
   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence ask_2x_s;
      ctrl_wr && rate_ask && wdata_q[mapper_pkg::MODE32_BIT];
   endsequence
   sequence even_done_s;
      edge_seen && select_q;
   endsequence
   rate_refused_a: assert property (
      ask_2x_s |=> refused_q && !rate2x_q && mode32_q)
      else $error("doubled rate accepted in 32-input mode");
   select_toggle_a: assert property (
      edge_seen |=> input_select == ~$past(input_select))
      else $error("input select did not alternate");
   pair_share_a: assert property (
      input_select == 16'h0000 || input_select == 16'hFFFF)
      else $error("converters not time-shared alike");
   odd_capture_a: assert property (
      edge_seen && !select_q |=> odd_next_q[0] == $past(sample_in[0]))
      else $error("odd word not from odd input");
   even_capture_a: assert property (
      edge_seen && select_q |=> raw_q[NC-1].even == $past(sample_in[NC-1]))
      else $error("even word not from even input");
   frame_fire_a: assert property (
      even_done_s |-> ##18 fire)
      else $error("frame not handed to lanes in time");
   pdn_zero_a: assert property (
      stage_v_q && converter_digital_powerdown[stage_idx_q]
      |=> frame_q[$past(stage_idx_q)] == '0)
      else $error("powered-down converter produced data");
   ana_zero_a: assert property (
      stage_v_q && converter_analog_powerdown[stage_idx_q]
      |=> frame_q[$past(stage_idx_q)] == '0)
      else $error("analog powered-down converter produced data");
   hpf_hold_a: assert property (
      stage_v_q && !hp_on |=> avg_q[{$past(stage_idx_q), 1'b0}]
                              == $past(avg_q[{stage_idx_q, 1'b0}]))
      else $error("filter state moved with filter off");
endmodule : input32_channel_mapper
`default_nettype wire

/* File: rtl/mapper_pkg.sv */
// package: register map, fields and types of the 32-input mapper
`default_nettype none
package mapper_pkg;
   localparam int NUM_CONV    = 16;
   localparam int GROUP_SIZE  = 4;
   localparam int NUM_GROUP   = NUM_CONV / GROUP_SIZE;
   localparam int SAMPLE_W    = 12;
   localparam int FRAME_BITS  = 2 * SAMPLE_W;
   localparam int GAIN_FRAC   = 5;
   localparam int AVG_FRAC    = 4;
   localparam int CORNER_BASE = 2;
   localparam int ADDR_W      = 8;
   // ---------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] DPDN_ADDR   = 8'h08;
   localparam logic [7:0] APDN_ADDR   = 8'h0C;
   localparam logic [7:0] HPFEN_ADDR  = 8'h10;
   localparam logic [7:0] CORNER_ADDR = 8'h14;
   localparam logic [7:0] TRIM_BASE   = 8'h40;
   // ---------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------
   localparam int MODE32_BIT  = 0;
   localparam int RATE2X_BIT  = 1;
   localparam int ACTIVE_BIT  = 0;
   localparam int REFUSED_BIT = 1;
   localparam int FRAMES_LSB  = 16;
   localparam logic [31:0] TRIM_RESET = 32'h0000_2020;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;
   typedef struct packed {
      logic [SAMPLE_W-1:0] odd;
      logic [SAMPLE_W-1:0] even;
   } pair_type;
   typedef struct packed {
      logic [7:0] even_offset;
      logic [7:0] odd_offset;
      logic [7:0] even_gain;
      logic [7:0] odd_gain;
   } trim_type;
   typedef enum logic [1:0] {
      WALK_IDLE = 2'b00,
      WALK_READ = 2'b01,
      WALK_LAST = 2'b11,
      WALK_FIRE = 2'b10
   } walk_type;
endpackage : mapper_pkg
`default_nettype wire

/* File: rtl/trim_memory.sv */
// trim memory: per-converter gain and offset words, registered read
`default_nettype none
module trim_memory #(
   parameter int DEPTH = 16
) (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [31:0]              wr_data,
   input  wire logic [3:0]               wr_strb,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output var  logic [31:0]              rd_data
);
   if (DEPTH < 2) begin : g_check
      $error("DEPTH must be at least two");
   end
   logic [31:0] mem_q [DEPTH];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= mapper_pkg::TRIM_RESET;
         end
      end else if (wr_en) begin
         for (int b = 0; b < 4; b++) begin
            if (wr_strb[b]) begin
               mem_q[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_data <= 32'h0000_0000;
      end else begin
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule : trim_memory
`default_nettype wire

/* File: rtl/lane_serializer.sv */
// lane serializer: one frame of odd word then even word, msb first
`default_nettype none
module lane_serializer (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 bit_en,
   input  wire logic                 load,
   input  wire mapper_pkg::pair_type word,
   output var  logic                 lane_bit,
   output var  logic                 frame_start
);
   localparam int TOP = mapper_pkg::FRAME_BITS - 1;
   logic [TOP:0] shift_q;
   logic [5:0]   left_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         shift_q     <= '0;
         left_q      <= 6'h00;
         lane_bit    <= 1'b0;
         frame_start <= 1'b0;
      end else if (load) begin
         shift_q     <= {word[TOP-1:0], 1'b0};
         left_q      <= 6'(TOP);
         lane_bit    <= word[TOP];
         frame_start <= 1'b1;
      end else if (bit_en) begin
         frame_start <= 1'b0;
         lane_bit    <= (left_q != 6'h00) ? shift_q[TOP] : 1'b0;
         shift_q     <= {shift_q[TOP-1:0], 1'b0};
         if (left_q != 6'h00) begin
            left_q <= left_q - 6'h01;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   odd_first_a: assert property (
      load |=> lane_bit == $past(word.odd[mapper_pkg::SAMPLE_W-1])
               && frame_start)
      else $error("lane did not start with the odd word msb");
endmodule : lane_serializer
`default_nettype wire

/* File: testbench/lane_receiver.sv */
// lane receiver model: rebuilds the odd and even words of every lane
`default_nettype none
module lane_receiver (
   input  wire logic                        clk,
   input  wire logic [15:0]                 lane_data,
   input  wire logic [15:0]                 lane_frame,
   output var  mapper_pkg::pair_type [15:0] rx_word,
   output var  logic                        rx_done
);
   timeunit 1ns / 100ps;
   logic [4:0] n_q = 5'h00;
   // first word is odd channel, second even; single rate only
   always_ff @(posedge clk) begin
      rx_done <= lane_frame == 16'h0000 && n_q == 5'h17;
      if ((&lane_frame) || n_q != 5'h00) begin
         for (int i = 0; i < 16; i++) begin
            rx_word[i] <= {rx_word[i][22:0], lane_data[i]};
         end
         n_q <= (&lane_frame) ? 5'h01
                : (n_q == 5'h17 ? 5'h00 : n_q + 5'h01);
      end
   end
endmodule : lane_receiver
`default_nettype wire

/* File: testbench/input32_channel_mapper_test.sv */
// testbench: register setup, link stimulus and lane checks of the mapper
`default_nettype none
module input32_channel_mapper_test;
   timeunit 1ns / 100ps;
   logic clk = 1'h0, reset = 1'h1, sample_clock_pin = 1'h0, rx_done;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_rvalid;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] input_select, converter_analog_powerdown, lane_data;
   logic [15:0] lane_frame, pd = 16'h0;
   logic [15:0][11:0] sample_in = '0;
   mapper_pkg::pair_type [15:0] rx_word, e, expq [$];
   mapper_pkg::trim_type trim [16] = '{default: mapper_pkg::TRIM_RESET};
   int n_errors = 0, compares = 0, seed = 23815;
   input32_channel_mapper #(.BIT_DIV(1)) i_dut (.*);
   lane_receiver i_rx (.*);
   initial forever #2 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic guard(input int k);
      check({31'h0, k < 200}, 32'h1);
      if (k >= 200) test_done();
   endtask : guard
   function automatic logic [11:0] scale(input logic [11:0] x,
         input logic [7:0] g, input logic [7:0] o, input logic p);
      return p ? 12'h000 : 12'((20'(x) * 20'(g)) >> 5) + {{4{o[7]}}, o};
   endfunction : scale
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] m, input logic err);
      int k;
      @(posedge clk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      for (k = 0; k < 200; k++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if ((w ? s_axi_bvalid : s_axi_rvalid) === 1'h1) break;
      end
      guard(k);
      {s_axi_bready, s_axi_rready} <= 2'h0;
      check({30'h0, w ? s_axi_bresp : s_axi_rresp},
            {30'h0, err ? mapper_pkg::RESP_DECERR : mapper_pkg::RESP_OKAY});
      if (!w) check(s_axi_rdata & m, d);
   endtask : bus
   task automatic frame();
      mapper_pkg::pair_type [15:0] x;
      logic [15:0][11:0] o, v;
      int k;
      for (int i = 0; i < 16; i++) begin
         o[i] = 12'($random(seed)) & 12'h3FF;
         v[i] = 12'($random(seed)) & 12'h3FF;
         x[i].odd = scale(o[i], trim[i].odd_gain, trim[i].odd_offset, pd[i]);
         x[i].even =
            scale(v[i], trim[i].even_gain, trim[i].even_offset, pd[i]);
      end
      expq.push_back(x);
      @(posedge clk);
      sample_in <= o;
      @(posedge clk);
      check({16'h0, input_select}, 32'h0);
      #1.3 sample_clock_pin = 1'h1;
      #24 sample_clock_pin = 1'h0;
      @(posedge clk);
      sample_in <= v;
      check({16'h0, input_select}, 32'hFFFF);
      #21.3 sample_clock_pin = 1'h1;
      #24 sample_clock_pin = 1'h0;
      for (k = 0; k < 200 && expq.size() != 0; k++) @(posedge clk);
      guard(k);
   endtask : frame
   initial forever begin
      @(posedge clk);
      if (rx_done === 1'h1) begin
         e = expq.pop_front();
         for (int i = 0; i < 16; i++) begin
            check({8'h00, rx_word[i]}, {8'h00, e[i]});
         end
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'h0;
      bus(1'h1, mapper_pkg::CTRL_ADDR, 32'h1, 32'h0, 1'h0);
      bus(1'h1, mapper_pkg::CTRL_ADDR, 32'h3, 32'h0, 1'h0);
      bus(1'h0, mapper_pkg::CTRL_ADDR, 32'h1, 32'h3, 1'h0);
      bus(1'h0, mapper_pkg::STATUS_ADDR, 32'h3, 32'h3, 1'h0);
      bus(1'h1, mapper_pkg::STATUS_ADDR, 32'h2, 32'h0, 1'h0);
      bus(1'h0, mapper_pkg::STATUS_ADDR, 32'h1, 32'h3, 1'h0);
      bus(1'h1, mapper_pkg::CORNER_ADDR, 32'hE4, 32'h0, 1'h0);
      bus(1'h0, mapper_pkg::CORNER_ADDR, 32'hE4, 32'hFF, 1'h0);
      bus(1'h0, 8'h30, 32'h0, 32'h0, 1'h1);
      repeat (2) frame();
      bus(1'h1, mapper_pkg::TRIM_BASE, 32'h2040, 32'h0, 1'h0);
      bus(1'h1, 8'h44, 32'h0300_2020, 32'h0, 1'h0);
      bus(1'h1, mapper_pkg::DPDN_ADDR, 32'h4, 32'h0, 1'h0);
      bus(1'h1, mapper_pkg::APDN_ADDR, 32'h20, 32'h0, 1'h0);
      trim[0] = 32'h2040;
      trim[1] = 32'h0300_2020;
      pd = 16'h0024;
      bus(1'h1, mapper_pkg::HPFEN_ADDR, 32'h1, 32'h0, 1'h0);
      bus(1'h0, mapper_pkg::HPFEN_ADDR, 32'h1, 32'hF, 1'h0);
      frame();
      check({16'h0, converter_analog_powerdown}, 32'h20);
      bus(1'h1, mapper_pkg::HPFEN_ADDR, 32'h0, 32'h0, 1'h0);
      frame();
      test_done();
   end
endmodule : input32_channel_mapper_test
`default_nettype wire
